// [verilog/sec_regs.svh]
// Timing counts and fixed values of the serial memory client framing block
`ifndef SEC_REGS_SVH
`define SEC_REGS_SVH

`define SEC_MCLK_MHZ        20
`define SEC_HOLDOFF_US      100
`define SEC_HOLDOFF_CYC     (`SEC_HOLDOFF_US * `SEC_MCLK_MHZ)
`define SEC_HOLD_W          11
`define SEC_LINK_PERIOD_NS  15
`define SEC_GLITCH_NS       50
`define SEC_GLITCH_CYC      ((`SEC_GLITCH_NS + `SEC_LINK_PERIOD_NS - 1) / `SEC_LINK_PERIOD_NS)
`define SEC_BYTE_BITS       8
`define SEC_ACK_SLOT        4'h8
`define SEC_FIFO_DEPTH      8
`define SEC_FIFO_WIDTH      9
`define SEC_IDLE_BYTE       8'hFF

`endif

// [verilog/sec_pkg.sv]
// Types shared by the serial memory client framing block
package sec_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX   = 5'h02,
        ST_RACK = 5'h04,
        ST_TX   = 5'h08,
        ST_TACK = 5'h10
    } sec_link_state_e;

    typedef logic [7:0] sec_byte_t;

endpackage

// [verilog/sec_fifo_if.sv]
// Valid/ready stream carrier between the link framing and the received-byte FIFO
`timescale 1ns/1ps
interface sec_fifo_if #(parameter int W = 9);
    logic         wr_valid;
    logic         wr_ready;
    logic [W-1:0] wr_data;
    logic         rd_valid;
    logic         rd_ready;
    logic [W-1:0] rd_data;

    modport fifo (input wr_valid, input wr_data, input rd_ready,
                  output wr_ready, output rd_valid, output rd_data);
    modport wr_side (output wr_valid, output wr_data, input wr_ready);
    modport rd_side (input rd_valid, input rd_data, output rd_ready);
endinterface

// [verilog/sec_filter.sv]
// Two-flop synchroniser followed by a spike suppression filter
`timescale 1ns/1ps
`include "sec_regs.svh"
module sec_filter
    import sec_pkg::*;
#(
    parameter int unsigned CYC = `SEC_GLITCH_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Raw pin and filtered level
    input  wire logic din,
    output logic      dout
);
    localparam int CW = $clog2(CYC + 1);

    logic          s1_q;
    logic          s2_q;
    logic          out_q;
    logic          out_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    assign dout = out_q;

    // A new level is taken only after it has held for CYC samples
    always_comb begin
        out_d = out_q;
        cnt_d = '0;
        if (s2_q != out_q) begin
            if (cnt_q == CW'(CYC - 1)) begin
                out_d = s2_q;
            end else begin
                cnt_d = cnt_q + CW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= 1'h1;
            s2_q  <= 1'h1;
            out_q <= 1'h1;
            cnt_q <= '0;
        end else begin
            s1_q  <= din;
            s2_q  <= s1_q;
            out_q <= out_d;
            cnt_q <= cnt_d;
        end
    end

    a_spike_blocked: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(out_q) |-> $past(cnt_q) == CW'(CYC - 1) && $past(s2_q) == out_q)
        else $error("filter output changed before the level was stable");
endmodule

// [verilog/sec_fifo.sv]
// Dual-clock FIFO with gray-coded pointers, valid and ready on both sides
`timescale 1ns/1ps
module sec_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 8
) (
    // Clocks and reset
    input  wire logic wr_clk,
    input  wire logic rd_clk,
    input  wire logic rst_n,
    // Stream
    sec_fifo_if.fifo  f
);
    localparam int AW = $clog2(DEPTH);

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction

    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [AW:0]  wbin_q;
    logic [AW:0]  wbin_d;
    logic [AW:0]  wgray_q;
    logic [AW:0]  rbin_q;
    logic [AW:0]  rbin_d;
    logic [AW:0]  rgray_q;
    logic [AW:0]  rg_s1_q;
    logic [AW:0]  rg_s2_q;
    logic [AW:0]  wg_s1_q;
    logic [AW:0]  wg_s2_q;
    logic         full;
    logic         empty;
    logic         push;
    logic         pop;

    assign full       = wgray_q == {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]};
    assign empty      = rgray_q == wg_s2_q;
    assign push       = f.wr_valid & ~full;
    assign pop        = f.rd_ready & ~empty;
    assign f.wr_ready = ~full;
    assign f.rd_valid = ~empty;
    assign f.rd_data  = mem_q[rbin_q[AW-1:0]];

    always_comb begin
        mem_d  = mem_q;
        wbin_d = push ? wbin_q + (AW+1)'(1) : wbin_q;
        rbin_d = pop ? rbin_q + (AW+1)'(1) : rbin_q;
        if (push) begin
            mem_d[wbin_q[AW-1:0]] = f.wr_data;
        end
    end

    // Storage holds data only, so it needs no reset
    always_ff @(posedge wr_clk) begin
        mem_q <= mem_d;
    end

    always_ff @(posedge wr_clk or negedge rst_n) begin
        if (!rst_n) begin
            wbin_q  <= '0;
            wgray_q <= '0;
            rg_s1_q <= '0;
            rg_s2_q <= '0;
        end else begin
            wbin_q  <= wbin_d;
            wgray_q <= to_gray(wbin_d);
            rg_s1_q <= rgray_q;
            rg_s2_q <= rg_s1_q;
        end
    end

    always_ff @(posedge rd_clk or negedge rst_n) begin
        if (!rst_n) begin
            rbin_q  <= '0;
            rgray_q <= '0;
            wg_s1_q <= '0;
            wg_s2_q <= '0;
        end else begin
            rbin_q  <= rbin_d;
            rgray_q <= to_gray(rbin_d);
            wg_s1_q <= wgray_q;
            wg_s2_q <= wg_s1_q;
        end
    end

    a_fifo_no_overrun: assert property (@(posedge wr_clk) disable iff (!rst_n)
        full && f.wr_valid |=> wbin_q == $past(wbin_q))
        else $error("write pointer moved while full");
    a_fifo_no_underrun: assert property (@(posedge rd_clk) disable iff (!rst_n)
        empty && f.rd_ready |=> rbin_q == $past(rbin_q))
        else $error("read pointer moved while empty");
endmodule

// [verilog/sec_client.sv]
// Client-side two-wire bus framing with power-up command hold-off
// What this block does
// - Sample incoming data on rising bus clock, change outgoing data on falling edge.
// - Bytes move most significant bit first, one bit per bus clock.
// - Each byte is nine clocks: eight data, then acknowledge or not-acknowledge.
// - Data line changes only while clock is low, steady while high.
// - Data change while clock is high is a Start or Stop, not data.
// - Any number of bytes may pass between Start and Stop.
// - Bus is idle only when clock and data are both high.
// - Short spikes on clock and data inputs are filtered out.
// - Commands are ignored after power-up until the hold-off ends.
// - Data falling while clock high is Start; it wakes the device.
// - Data rising while clock high is Stop; device returns to standby.
// - Transmitter releases data after eighth clock so receiver can acknowledge.
`timescale 1ns/1ps
`include "sec_regs.svh"
module sec_client
    import sec_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = `SEC_FIFO_DEPTH
) (
    // System clock and power-on reset
    input  wire logic       MCLK,
    input  wire logic       RESETN,
    // Link sampling clock and bus pins
    input  wire logic       LINK_CLK,
    input  wire logic       SCL_I,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE_N,
    // Received bytes, bit 8 marks the first byte after Start
    output logic [8:0]      RX_DATA,
    output logic            RX_VALID,
    input  wire logic       RX_READY,
    // Bytes to send when the host reads
    input  wire sec_byte_t  TX_DATA,
    input  wire logic       TX_VALID,
    output logic            TX_READY,
    // Status
    output logic            CMD_READY,
    output logic            BUS_IDLE,
    output logic            BUS_BUSY
);
    sec_fifo_if #(.W(`SEC_FIFO_WIDTH)) rx_if ();

    // ---- System clock domain ----
    logic [`SEC_HOLD_W-1:0] hold_cnt_q;
    logic [`SEC_HOLD_W-1:0] hold_cnt_d;
    logic                   cmd_rdy_q;
    logic                   cmd_rdy_d;
    sec_byte_t              tx_hold_q;
    sec_byte_t              tx_hold_d;
    logic                   req_tgl_q;
    logic                   req_tgl_d;
    logic                   tx_rdy_q;
    logic                   tx_rdy_d;
    logic                   ack_s1_q;
    logic                   ack_s2_q;
    logic                   ack_p_q;
    logic                   rxv_q;
    logic                   rxv_d;
    logic [8:0]             rxd_q;
    logic [8:0]             rxd_d;
    logic                   idle_s1_q;
    logic                   idle_s2_q;
    logic                   idle_out_q;
    logic                   busy_s1_q;
    logic                   busy_s2_q;
    logic                   busy_out_q;
    // Link-domain sources read by the synchronisers above
    logic                   ack_tgl_q;
    logic                   idle_l_q;
    logic                   busy_l_q;

    assign CMD_READY      = cmd_rdy_q;
    assign TX_READY       = tx_rdy_q;
    assign RX_VALID       = rxv_q;
    assign RX_DATA        = rxd_q;
    assign BUS_IDLE       = idle_out_q;
    assign BUS_BUSY       = busy_out_q;
    assign rx_if.rd_ready = ~rxv_q | RX_READY;

    always_comb begin
        hold_cnt_d = hold_cnt_q;
        cmd_rdy_d  = cmd_rdy_q;
        if (!cmd_rdy_q) begin
            if (hold_cnt_q == `SEC_HOLD_W'(`SEC_HOLDOFF_CYC - 1)) begin
                cmd_rdy_d = 1'h1;
            end else begin
                hold_cnt_d = hold_cnt_q + `SEC_HOLD_W'(1);
            end
        end
    end

    // Toggle handshake: the holding byte stays put until the link side answers
    always_comb begin
        tx_hold_d = tx_hold_q;
        req_tgl_d = req_tgl_q;
        tx_rdy_d  = tx_rdy_q;
        if (ack_s2_q != ack_p_q) begin
            tx_rdy_d = 1'h1;
        end
        if (TX_VALID && tx_rdy_q) begin
            tx_hold_d = TX_DATA;
            req_tgl_d = ~req_tgl_q;
            tx_rdy_d  = 1'h0;
        end
    end

    always_comb begin
        rxv_d = rxv_q;
        rxd_d = rxd_q;
        if (rx_if.rd_ready) begin
            rxv_d = rx_if.rd_valid;
            rxd_d = rx_if.rd_data;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            hold_cnt_q <= '0;
            cmd_rdy_q  <= 1'h0;
            tx_hold_q  <= `SEC_IDLE_BYTE;
            req_tgl_q  <= 1'h0;
            tx_rdy_q   <= 1'h1;
            ack_s1_q   <= 1'h0;
            ack_s2_q   <= 1'h0;
            ack_p_q    <= 1'h0;
            rxv_q      <= 1'h0;
            rxd_q      <= 9'h000;
            idle_s1_q  <= 1'h0;
            idle_s2_q  <= 1'h0;
            idle_out_q <= 1'h0;
            busy_s1_q  <= 1'h0;
            busy_s2_q  <= 1'h0;
            busy_out_q <= 1'h0;
        end else begin
            hold_cnt_q <= hold_cnt_d;
            cmd_rdy_q  <= cmd_rdy_d;
            tx_hold_q  <= tx_hold_d;
            req_tgl_q  <= req_tgl_d;
            tx_rdy_q   <= tx_rdy_d;
            ack_s1_q   <= ack_tgl_q;
            ack_s2_q   <= ack_s1_q;
            ack_p_q    <= ack_s2_q;
            rxv_q      <= rxv_d;
            rxd_q      <= rxd_d;
            idle_s1_q  <= idle_l_q;
            idle_s2_q  <= idle_s1_q;
            idle_out_q <= idle_s2_q;
            busy_s1_q  <= busy_l_q;
            busy_s2_q  <= busy_s1_q;
            busy_out_q <= busy_s2_q;
        end
    end

    // ---- Link clock domain ----
    logic            scl_f;
    logic            sda_f;
    logic            scl_p_q;
    logic            sda_p_q;
    logic            rdy_s1_q;
    logic            rdy_s2_q;
    logic            req_s1_q;
    logic            req_s2_q;
    logic            req_p_q;
    sec_link_state_e st_q;
    sec_link_state_e st_d;
    logic [3:0]      cnt_q;
    logic [3:0]      cnt_d;
    sec_byte_t       sh_q;
    sec_byte_t       sh_d;
    logic            first_q;
    logic            first_d;
    logic            txdir_q;
    logic            txdir_d;
    logic            nack_q;
    logic            nack_d;
    logic            oen_q;
    logic            oen_d;
    logic            tx_full_q;
    logic            tx_full_d;
    sec_byte_t       tx_byte_q;
    sec_byte_t       tx_byte_d;
    logic            ack_tgl_d;
    logic            sda_o_q;
    logic            push;
    logic            scl_rise;
    logic            scl_fall;
    logic            start_ev;
    logic            stop_ev;
    sec_byte_t       next_tx;

    sec_filter u_scl_filt (.clk(LINK_CLK), .rst_n(RESETN), .din(SCL_I), .dout(scl_f));
    sec_filter u_sda_filt (.clk(LINK_CLK), .rst_n(RESETN), .din(SDA_I), .dout(sda_f));

    sec_fifo #(.W(`SEC_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .wr_clk (LINK_CLK),
        .rd_clk (MCLK),
        .rst_n  (RESETN),
        .f      (rx_if.fifo)
    );

    assign SDA_O    = sda_o_q;
    assign SDA_OE_N = oen_q;
    assign scl_rise = scl_f & ~scl_p_q;
    assign scl_fall = ~scl_f & scl_p_q;
    assign start_ev = scl_f & scl_p_q & sda_p_q & ~sda_f;
    assign stop_ev  = scl_f & scl_p_q & ~sda_p_q & sda_f;
    assign next_tx  = tx_full_q ? tx_byte_q : `SEC_IDLE_BYTE;
    assign rx_if.wr_valid = push;
    assign rx_if.wr_data  = {first_q, sh_q};

    always_comb begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        sh_d      = sh_q;
        first_d   = first_q;
        txdir_d   = txdir_q;
        nack_d    = nack_q;
        oen_d     = oen_q;
        tx_full_d = tx_full_q;
        tx_byte_d = tx_byte_q;
        ack_tgl_d = ack_tgl_q;
        push      = 1'h0;
        if (stop_ev) begin
            st_d  = ST_IDLE;
            oen_d = 1'h1;
        end else if (start_ev) begin
            if (rdy_s2_q) begin
                st_d    = ST_RX;
                cnt_d   = 4'h0;
                first_d = 1'h1;
                txdir_d = 1'h0;
                oen_d   = 1'h1;
            end
        end else begin
            case (st_q)
                ST_IDLE: begin
                end
                ST_RX: begin
                    if (scl_rise) begin
                        sh_d  = {sh_q[6:0], sda_f};
                        cnt_d = cnt_q + 4'h1;
                    end
                    if (scl_fall && cnt_q == `SEC_ACK_SLOT) begin
                        push    = rx_if.wr_ready;
                        oen_d   = ~rx_if.wr_ready;
                        txdir_d = txdir_q | (first_q & sh_q[0]);
                        first_d = 1'h0;
                        st_d    = ST_RACK;
                    end
                end
                ST_RACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (txdir_q) begin
                            sh_d      = next_tx;
                            oen_d     = next_tx[7];
                            tx_full_d = 1'h0;
                            st_d      = ST_TX;
                        end else begin
                            oen_d = 1'h1;
                            st_d  = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end
                    if (scl_fall) begin
                        if (cnt_q == `SEC_ACK_SLOT) begin
                            oen_d = 1'h1;
                            st_d  = ST_TACK;
                        end else begin
                            sh_d  = {sh_q[6:0], 1'h0};
                            oen_d = sh_q[6];
                        end
                    end
                end
                ST_TACK: begin
                    if (scl_rise) begin
                        nack_d = sda_f;
                    end
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (nack_q) begin
                            st_d = ST_IDLE;
                        end else begin
                            sh_d      = next_tx;
                            oen_d     = next_tx[7];
                            tx_full_d = 1'h0;
                            st_d      = ST_TX;
                        end
                    end
                end
                default: begin
                    st_d  = ST_IDLE;
                    oen_d = 1'h1;
                end
            endcase
        end
        if (req_s2_q != req_p_q) begin
            tx_full_d = 1'h1;
            tx_byte_d = tx_hold_q;
            ack_tgl_d = ~ack_tgl_q;
        end
    end

    always_ff @(posedge LINK_CLK or negedge RESETN) begin
        if (!RESETN) begin
            scl_p_q   <= 1'h1;
            sda_p_q   <= 1'h1;
            rdy_s1_q  <= 1'h0;
            rdy_s2_q  <= 1'h0;
            req_s1_q  <= 1'h0;
            req_s2_q  <= 1'h0;
            req_p_q   <= 1'h0;
            st_q      <= ST_IDLE;
            cnt_q     <= 4'h0;
            sh_q      <= 8'h00;
            first_q   <= 1'h0;
            txdir_q   <= 1'h0;
            nack_q    <= 1'h0;
            oen_q     <= 1'h1;
            tx_full_q <= 1'h0;
            tx_byte_q <= `SEC_IDLE_BYTE;
            ack_tgl_q <= 1'h0;
            idle_l_q  <= 1'h0;
            busy_l_q  <= 1'h0;
            sda_o_q   <= 1'h0;
        end else begin
            scl_p_q   <= scl_f;
            sda_p_q   <= sda_f;
            rdy_s1_q  <= cmd_rdy_q;
            rdy_s2_q  <= rdy_s1_q;
            req_s1_q  <= req_tgl_q;
            req_s2_q  <= req_s1_q;
            req_p_q   <= req_s2_q;
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            sh_q      <= sh_d;
            first_q   <= first_d;
            txdir_q   <= txdir_d;
            nack_q    <= nack_d;
            oen_q     <= oen_d;
            tx_full_q <= tx_full_d;
            tx_byte_q <= tx_byte_d;
            ack_tgl_q <= ack_tgl_d;
            idle_l_q  <= scl_f & sda_f;
            busy_l_q  <= st_d != ST_IDLE;
            sda_o_q   <= 1'h0;
        end
    end

    sequence s_rx_byte_end;
        st_q == ST_RX && scl_fall && cnt_q == `SEC_ACK_SLOT;
    endsequence
    sequence s_tx_byte_end;
        st_q == ST_TX && scl_fall && cnt_q == `SEC_ACK_SLOT;
    endsequence

    a_drive_on_fall: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        $changed(oen_q) |-> $past(scl_fall) || $past(start_ev) || $past(stop_ev))
        else $error("data line drive changed outside a falling clock");
    a_sample_on_rise: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        st_q == ST_RX && scl_rise && !start_ev && !stop_ev |=> sh_q[0] == $past(sda_f))
        else $error("incoming bit not captured on rising clock");
    a_ack_ninth_slot: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        s_rx_byte_end ##0 (rx_if.wr_ready && !stop_ev && !start_ev) |=> !oen_q && st_q == ST_RACK)
        else $error("received byte not acknowledged in ninth clock");
    a_tx_release_eighth: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        s_tx_byte_end ##0 (!stop_ev && !start_ev) |=> oen_q && st_q == ST_TACK)
        else $error("transmitter kept data line after eighth clock");
    a_tx_msb_first: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        $rose(st_q == ST_TX) |-> oen_q == sh_q[7] && cnt_q == 4'h0)
        else $error("transmitted byte did not start with its top bit");
    a_start_wakes: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        start_ev && !stop_ev && rdy_s2_q |=> st_q == ST_RX && cnt_q == 4'h0 && first_q)
        else $error("start event did not begin a receive byte");
    a_stop_standby: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        stop_ev |=> st_q == ST_IDLE && oen_q)
        else $error("stop event did not return to standby");
    a_holdoff_ignores: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        !rdy_s2_q |=> st_q == ST_IDLE)
        else $error("command taken before power-up hold-off ended");
    a_holdoff_count: assert property (@(posedge MCLK) disable iff (!RESETN)
        $rose(cmd_rdy_q) |-> $past(hold_cnt_q) == `SEC_HOLD_W'(`SEC_HOLDOFF_CYC - 1))
        else $error("hold-off ended at the wrong count");
    a_idle_level: assert property (@(posedge LINK_CLK) disable iff (!RESETN)
        idle_l_q |-> $past(scl_f) && $past(sda_f))
        else $error("idle reported while a bus line was low");
endmodule

// [testbench/sec_host.sv]
// Behavioural bus host that makes the bus clock and drives the data line
`timescale 1ns/1ps
module sec_host (
    // Timing reference and resolved data line
    input  wire logic clk,
    input  wire logic sda,
    // Host lines, a released data line reads back high
    output logic      scl,
    output logic      sda_q
);
    initial begin
        scl = 1'b1;
        sda_q = 1'b1;
    end
    task automatic q();
        repeat (3) @(negedge clk);
    endtask
    task automatic start();
        sda_q = 1'b1;
        scl = 1'b1;
        q();
        sda_q = 1'b0;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic stop();
        sda_q = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_q = 1'b1;
        q();
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_q = b;
        q();
        scl = 1'b1;
        q();
        r = sda;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic xfer(input logic [7:0] w, input logic ai, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(w[i], r[i]);
        end
        bit_io(ai, a);
    endtask
    task automatic spike();
        sda_q = 1'b0;
        #20;
        sda_q = 1'b1;
    endtask
endmodule

// [testbench/tb.sv]
// Self-checking bench for the client framing block
`timescale 1ns/1ps
module tb;
    import sec_pkg::*;
    logic       mclk, link_clk, resetn, rx_ready, tx_valid, scl, h_sda;
    logic       sda_o, sda_oe_n, rx_valid, tx_ready, cmd_ready, bus_idle, bus_busy;
    logic [8:0] rx_data;
    sec_byte_t  tx_data;
    wire        sda = h_sda & (sda_oe_n | sda_o);
    int         n_mismatch = 0;
    int         checked = 0;
    int         cyc = 0;
    logic [7:0] r;
    logic       a;
    // Eight FIFO words plus the RX output register
    localparam int rx_slots = 9;

    sec_client dut (.MCLK(mclk), .RESETN(resetn), .LINK_CLK(link_clk), .SCL_I(scl), .SDA_I(sda),
        .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .CMD_READY(cmd_ready),
        .BUS_IDLE(bus_idle), .BUS_BUSY(bus_busy));
    sec_host h (.clk(mclk), .sda(sda), .scl(scl), .sda_q(h_sda));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        link_clk = 1'b0;
        #3;
        forever #7.5 link_clk = ~link_clk;
    end
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic pop(input logic [8:0] exp);
        for (int n = 0; n < 40 && rx_valid !== 1'b1; n++) begin
            @(negedge mclk);
        end
        chk(rx_data, exp);
        rx_ready = 1'b1;
        @(negedge mclk);
        rx_ready = 1'b0;
        @(negedge mclk);
    endtask
    task automatic t_holdoff();
        int c;
        chk(9'(cmd_ready), 9'h000);
        h.start();
        h.xfer(8'hA0, 1'b1, r, a);
        h.stop();
        chk(9'(a), 9'h001);
        chk(9'(rx_valid), 9'h000);
        for (c = 0; c < 2100 && cmd_ready !== 1'b1; c++) begin
            @(negedge mclk);
        end
        c = ($time - 250) / 50;
        chk(9'(c >= 1999 && c <= 2003), 9'h001);
        $display("test holdoff done");
    endtask
    task automatic t_write();
        logic [7:0] w[3];
        w = '{8'hA4, 8'h5B, 8'h00};
        h.start();
        repeat (3) @(negedge mclk);
        chk(9'({bus_busy, bus_idle}), 9'h002);
        foreach (w[i]) begin
            h.xfer(w[i], 1'b1, r, a);
            chk(9'(a), 9'h000);
        end
        h.stop();
        repeat (12) @(negedge mclk);
        chk(9'({bus_busy, bus_idle}), 9'h001);
        pop(9'h1A4);
        pop(9'h05B);
        pop(9'h000);
        $display("test write done");
    endtask
    task automatic t_full();
        h.start();
        for (int i = 0; i <= rx_slots; i++) begin
            h.xfer(8'(2 * i), 1'b1, r, a);
            chk(9'(a), 9'(i >= rx_slots));
        end
        h.stop();
        pop(9'h100);
        for (int i = 1; i < rx_slots; i++) begin
            pop(9'(2 * i));
        end
        repeat (2) @(negedge mclk);
        chk(9'(rx_valid), 9'h000);
        $display("test full done");
    endtask
    task automatic t_read();
        tx_data = 8'hC3;
        tx_valid = 1'b1;
        @(negedge mclk);
        tx_valid = 1'b0;
        chk(9'(tx_ready), 9'h000);
        repeat (20) @(negedge mclk);
        chk(9'(tx_ready), 9'h001);
        h.start();
        h.xfer(8'hA1, 1'b1, r, a);
        chk(9'(a), 9'h000);
        h.xfer(8'hFF, 1'b0, r, a);
        chk(9'(r), 9'h0C3);
        h.xfer(8'hFF, 1'b1, r, a);
        chk(9'(r), 9'h0FF);
        chk(9'(sda_oe_n), 9'h001);
        h.stop();
        pop(9'h1A1);
        $display("test read done");
    endtask
    task automatic t_glitch();
        h.spike();
        repeat (20) @(negedge mclk);
        chk(9'({bus_busy, bus_idle}), 9'h001);
        chk(9'(rx_valid), 9'h000);
        h.start();
        fork
            h.xfer(8'h5A, 1'b1, r, a);
            begin
                repeat (17) @(negedge mclk);
                h.spike();
            end
        join
        chk(9'(a), 9'h000);
        h.stop();
        pop(9'h15A);
        $display("test glitch done");
    endtask
    initial begin
        resetn = 1'b0;
        rx_ready = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        repeat (5) @(negedge mclk);
        resetn = 1'b1;
        t_holdoff();
        t_write();
        t_full();
        t_read();
        t_glitch();
        report_and_stop();
    end
endmodule
